// [core/cdt_pkg.sv]
// Package: register map, field layout and carrier types for the timing override bank
package cdt_pkg;

   // ==========================================================
   // Register map (indirect page 0x00)
   localparam logic [7:0] CDT_PAGE          = 8'h00;
   localparam logic [7:0] CDT_OFF_CLK_PREP  = 8'h40;
   localparam logic [7:0] CDT_OFF_CLK_ZERO  = 8'h41;
   localparam logic [7:0] CDT_OFF_CLK_TRAIL = 8'h42;
   localparam logic [7:0] CDT_OFF_CLK_POST  = 8'h43;
   localparam logic [7:0] CDT_OFF_HS_PREP   = 8'h44;
   localparam logic [7:0] CDT_OFF_HS_ZERO   = 8'h45;
   localparam logic [7:0] CDT_OFF_HS_TRAIL  = 8'h46;
   localparam logic [7:0] CDT_OFF_HS_EXIT   = 8'h47;
   localparam logic [7:0] CDT_OFF_PLX       = 8'h48;

   // ==========================================================
   // Parameter indices (index = offset - first offset)
   localparam int CDT_NUM       = 9;
   localparam int CDT_IX_CLK_PREP  = 0;
   localparam int CDT_IX_CLK_ZERO  = 1;
   localparam int CDT_IX_CLK_TRAIL = 2;
   localparam int CDT_IX_CLK_POST  = 3;
   localparam int CDT_IX_HS_PREP   = 4;
   localparam int CDT_IX_HS_ZERO   = 5;
   localparam int CDT_IX_HS_TRAIL  = 6;
   localparam int CDT_IX_HS_EXIT   = 7;
   localparam int CDT_IX_PLX       = 8;

   // ==========================================================
   // Field layout and reset values
   localparam int         CDT_OV_BIT     = 7;
   localparam int         CDT_VAL_W      = 7;
   localparam logic       CDT_OV_RST     = 1'b0;
   localparam logic [6:0] CDT_VAL_RST    = 7'h00;
   localparam logic [7:0] CDT_RD_UNMAP   = 8'h00;

   // ==========================================================
   // Carrier types
   typedef logic [CDT_VAL_W-1:0]            cdt_val_t;
   typedef logic [CDT_NUM-1:0][CDT_VAL_W-1:0] cdt_set_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cdt_req_s;

endpackage : cdt_pkg

// [core/cdt_timing_override.sv]
// Timing override register bank for the CSI-2 transmit port D-PHY
`timescale 1ns/100ps

// Behaviour
// - Clock post time: auto unless override set
// - HS prepare time: auto unless override set
// - HS zero time: auto unless override set
// - HS trail time: auto unless override set
// - HS exit time: auto unless override set
// - Plx time: auto unless override set
// - Value field read-only auto while override clear
// - All override enables reset to zero
// - Clock prepare time: auto unless override set
// - Clock zero time: auto unless override set
// - Clock trail time: auto unless override set
module cdt_timing_override
   import cdt_pkg::*;
(
   // Clock and reset
   input  wire logic     i_clk,
   input  wire logic     i_rst_n,
   // Indirect register access
   input  wire cdt_req_s i_req,
   output logic [7:0]    o_rd_data,
   output logic          o_rd_valid,
   // Automatically derived timing values from the PHY sequencer
   input  wire cdt_set_t i_auto,
   // Effective timing applied to lane sequencing
   output cdt_set_t      o_eff,
   output logic [CDT_NUM-1:0] o_ovr
);

   // ==========================================================
   // Address decode
   function automatic logic hit(input logic [7:0] page, input logic [7:0] addr);
      hit = (page == CDT_PAGE) && (addr >= CDT_OFF_CLK_PREP) && (addr <= CDT_OFF_PLX);
   endfunction

   function automatic logic [3:0] idx(input logic [7:0] addr);
      logic [7:0] d;
      d   = addr - CDT_OFF_CLK_PREP;
      idx = d[3:0];
   endfunction

   logic [CDT_NUM-1:0] ovr_q;
   cdt_set_t           val_q;
   cdt_set_t           eff_q;
   logic [7:0]         rd_data_q;
   logic               rd_valid_q;
   logic               req_hit;
   logic [3:0]         req_ix;

   assign req_hit = hit(i_req.page, i_req.addr);
   assign req_ix  = idx(i_req.addr);

   // ==========================================================
   // Per-parameter override storage
   genvar g;
   generate
      for (g = 0; g < CDT_NUM; g++) begin : g_par
         // Override enable: plain read/write bit, cleared by reset
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               ovr_q[g] <= CDT_OV_RST;
            end else if (i_req.wr && req_hit && req_ix == 4'(g)) begin
               ovr_q[g] <= i_req.wdata[CDT_OV_BIT];
            end
         end

         // Value field: tracks auto while not overridden; a write that sets the
         // override bit also loads the value field from the same write data
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               val_q[g] <= CDT_VAL_RST;
            end else if (i_req.wr && req_hit && req_ix == 4'(g)
                         && i_req.wdata[CDT_OV_BIT]) begin
               val_q[g] <= i_req.wdata[CDT_VAL_W-1:0];
            end else if (!ovr_q[g]) begin
               val_q[g] <= i_auto[g];
            end
         end

         // Effective value handed to the lane sequencer
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               eff_q[g] <= CDT_VAL_RST;
            end else begin
               eff_q[g] <= ovr_q[g] ? val_q[g] : i_auto[g];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read path: one cycle latency, unmapped reads return zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_data_q  <= CDT_RD_UNMAP;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= i_req.rd;
         if (i_req.rd && req_hit) begin
            rd_data_q <= {ovr_q[req_ix],
                          ovr_q[req_ix] ? val_q[req_ix] : i_auto[req_ix]};
         end else begin
            rd_data_q <= CDT_RD_UNMAP;
         end
      end
   end

   assign o_rd_data  = rd_data_q;
   assign o_rd_valid = rd_valid_q;
   assign o_eff      = eff_q;  // Straight from flops
   assign o_ovr      = ovr_q;

   // ==========================================================
   // Assertions
   property p_clk_post;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_rst_n ##1 i_rst_n |-> o_eff[CDT_IX_CLK_POST] == ($past(ovr_q[CDT_IX_CLK_POST])
         ? $past(val_q[CDT_IX_CLK_POST]) : $past(i_auto[CDT_IX_CLK_POST]));
   endproperty
   a_clk_post: assert property (p_clk_post) else $error("clk post select");

   property p_hs_prep;
      @(posedge i_clk) disable iff (!i_rst_n)
      ovr_q[CDT_IX_HS_PREP] |=> o_eff[CDT_IX_HS_PREP] == $past(val_q[CDT_IX_HS_PREP]);
   endproperty
   a_hs_prep: assert property (p_hs_prep) else $error("hs prepare override");

   property p_hs_zero;
      @(posedge i_clk) disable iff (!i_rst_n)
      !ovr_q[CDT_IX_HS_ZERO] |=> o_eff[CDT_IX_HS_ZERO] == $past(i_auto[CDT_IX_HS_ZERO]);
   endproperty
   a_hs_zero: assert property (p_hs_zero) else $error("hs zero auto");

   property p_hs_trail;
      @(posedge i_clk) disable iff (!i_rst_n)
      ovr_q[CDT_IX_HS_TRAIL] |=> o_eff[CDT_IX_HS_TRAIL] == $past(val_q[CDT_IX_HS_TRAIL]);
   endproperty
   a_hs_trail: assert property (p_hs_trail) else $error("hs trail override");

   property p_hs_exit;
      @(posedge i_clk) disable iff (!i_rst_n)
      !ovr_q[CDT_IX_HS_EXIT] |=> o_eff[CDT_IX_HS_EXIT] == $past(i_auto[CDT_IX_HS_EXIT]);
   endproperty
   a_hs_exit: assert property (p_hs_exit) else $error("hs exit auto");

   property p_plx;
      @(posedge i_clk) disable iff (!i_rst_n)
      ovr_q[CDT_IX_PLX] |=> o_eff[CDT_IX_PLX] == $past(val_q[CDT_IX_PLX]);
   endproperty
   a_plx: assert property (p_plx) else $error("plx override");

   property p_readback;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_req.rd && req_hit && !ovr_q[req_ix]
         |=> o_rd_data == {1'b0, $past(i_auto[req_ix])} && o_rd_valid;
   endproperty
   a_readback: assert property (p_readback) else $error("auto readback");

   property p_ignore_wr;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_req.wr && req_hit && !i_req.wdata[CDT_OV_BIT] && !ovr_q[req_ix]
         |=> val_q[$past(req_ix)] == $past(i_auto[req_ix]);
   endproperty
   a_ignore_wr: assert property (p_ignore_wr) else $error("write not ignored");

   property p_reset;
      @(posedge i_clk) $past(!i_rst_n) |-> ovr_q == '0 && o_eff == '0;
   endproperty
   a_reset: assert property (p_reset) else $error("override not cleared");

   property p_clk_prep;
      @(posedge i_clk) disable iff (!i_rst_n)
      ovr_q[CDT_IX_CLK_PREP] |=> o_eff[CDT_IX_CLK_PREP] == $past(val_q[CDT_IX_CLK_PREP]);
   endproperty
   a_clk_prep: assert property (p_clk_prep) else $error("clk prepare override");

   property p_clk_zero;
      @(posedge i_clk) disable iff (!i_rst_n)
      !ovr_q[CDT_IX_CLK_ZERO] |=> o_eff[CDT_IX_CLK_ZERO] == $past(i_auto[CDT_IX_CLK_ZERO]);
   endproperty
   a_clk_zero: assert property (p_clk_zero) else $error("clk zero auto");

   property p_clk_trail;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_req.wr && req_hit && req_ix == 4'(CDT_IX_CLK_TRAIL) && i_req.wdata[CDT_OV_BIT]
         ##1 !(i_req.wr && req_hit)
         |=> o_eff[CDT_IX_CLK_TRAIL] == $past(i_req.wdata[CDT_VAL_W-1:0], 2);
   endproperty
   a_clk_trail: assert property (p_clk_trail) else $error("clk trail write");

   property p_eff_auto;
      @(posedge i_clk) disable iff (!i_rst_n)
      (ovr_q == '0) [*2] |-> o_eff == $past(i_auto);
   endproperty
   a_eff_auto: assert property (p_eff_auto) else $error("effective set stale");

   c_set_ovr:   cover property (@(posedge i_clk) disable iff (!i_rst_n)
                               $rose(ovr_q[CDT_IX_HS_ZERO]));
   c_read_ovr:  cover property (@(posedge i_clk) disable iff (!i_rst_n)
                               o_rd_valid && o_rd_data[CDT_OV_BIT]);
   c_drop_ovr:  cover property (@(posedge i_clk) disable iff (!i_rst_n)
                               $fell(ovr_q[CDT_IX_CLK_POST]));

endmodule : cdt_timing_override

// [test/cdt_auto_model.sv]
// Model of the PHY sequencer that supplies the automatic timing values
`timescale 1ns/100ps

// ==========================================================
// Automatic timing source
module cdt_auto_model
   import cdt_pkg::*;
(
   // Scenario selector
   input  wire logic [3:0] i_gen,
   // Derived values, one per index
   output cdt_set_t        o_auto
);
   // Distinct per index so a swapped index shows; no real timing math
   always_comb begin
      for (int k = 0; k < CDT_NUM; k++) begin
         o_auto[k] = 7'(i_gen * 16 + k * 5 + 1);
      end
   end
endmodule // cdt_auto_model

// [test/cdt_timing_override_tb_top.sv]
// Self-checking bench for the timing override register bank
`timescale 1ns/100ps

// ==========================================================
// Bench top
module cdt_timing_override_tb_top;
   import cdt_pkg::*;
   logic               clk;
   logic               rst_n;
   cdt_req_s           req;
   logic [7:0]         rd_data;
   logic               rd_valid;
   cdt_set_t           auto_v;
   cdt_set_t           eff;
   logic [CDT_NUM-1:0] ovr;
   logic [3:0]         gen;
   int                 miscompares;
   int                 num_checks;
   int                 cycles;

   cdt_timing_override i_cdt_timing_override (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_auto(auto_v), .o_eff(eff), .o_ovr(ovr));
   cdt_auto_model i_cdt_auto_model (.i_gen(gen), .o_auto(auto_v));

   function automatic logic [6:0] exp_auto(int k);
      return 7'(gen * 16 + k * 5 + 1);
   endfunction

   function automatic logic [6:0] held(int k);
      return 7'(8'h70 - k * 3);
   endfunction

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One request per call, held until the next call or bus_idle, so that
   // back-to-back calls never assign req twice in one time step
   task automatic access(input logic w, input logic [7:0] pg, ad, wd);
      req <= '{wr: w, rd: !w, page: pg, addr: ad, wdata: wd};
      @(negedge clk);
   endtask

   // Drop the request and let cycles pass with the bus quiet
   task automatic bus_idle(input int n);
      req <= '0;
      repeat (n) @(negedge clk);
   endtask

   task automatic rd_chk(input logic [7:0] pg, ad, exp);
      access(1'b0, pg, ad, 8'h00);
      chk("rd_valid", 9'h001, {8'h00, rd_valid});
      chk("rd_data", {1'b0, exp}, {1'b0, rd_data});
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard, well above the roughly 80 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         conclude();
      end
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      req = '0;
      gen = 4'h1;
      miscompares = 0;
      num_checks = 0;
      cycles = 0;
      repeat (12) @(negedge clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
      chk("ovr", 9'h000, ovr);
      for (int k = 0; k < CDT_NUM; k++) begin
         chk("eff", {2'b00, exp_auto(k)}, {2'b00, eff[k]});
         access(1'b1, CDT_PAGE, 8'(CDT_OFF_CLK_PREP + k), 8'h55);
         rd_chk(CDT_PAGE, 8'(CDT_OFF_CLK_PREP + k), {1'b0, exp_auto(k)});
      end
      // Back-to-back override writes, then auto source moves underneath
      for (int k = 0; k < CDT_NUM; k++) begin
         access(1'b1, CDT_PAGE, 8'(CDT_OFF_CLK_PREP + k), {1'b1, held(k)});
      end
      gen <= 4'h2;
      bus_idle(2);
      chk("ovr", 9'h1ff, ovr);
      for (int k = 0; k < CDT_NUM; k++) begin
         chk("eff", {2'b00, held(k)}, {2'b00, eff[k]});
         rd_chk(CDT_PAGE, 8'(CDT_OFF_CLK_PREP + k), {1'b1, held(k)});
      end
      // Drop odd overrides; those fall back to auto at once
      for (int k = 1; k < CDT_NUM; k += 2) begin
         access(1'b1, CDT_PAGE, 8'(CDT_OFF_CLK_PREP + k), 8'h00);
      end
      access(1'b1, 8'h01, CDT_OFF_CLK_POST, 8'hff);
      access(1'b1, CDT_PAGE, 8'h49, 8'hff);
      bus_idle(1);
      chk("ovr", 9'h155, ovr);
      for (int k = 0; k < CDT_NUM; k++) begin
         chk("eff", {2'b00, (k % 2) ? exp_auto(k) : held(k)}, {2'b00, eff[k]});
         rd_chk(CDT_PAGE, 8'(CDT_OFF_CLK_PREP + k),
                (k % 2) ? {1'b0, exp_auto(k)} : {1'b1, held(k)});
      end
      // Unmapped reads answer zero; data drops after one cycle
      rd_chk(8'h01, CDT_OFF_CLK_POST, CDT_RD_UNMAP);
      rd_chk(CDT_PAGE, 8'h49, CDT_RD_UNMAP);
      rd_chk(CDT_PAGE, CDT_OFF_PLX, {1'b1, held(8)});
      bus_idle(1);
      chk("rd_idle", 9'h000, {rd_valid, rd_data});
      // New override value with a quiet cycle after it reaches the sequencer
      access(1'b1, CDT_PAGE, CDT_OFF_CLK_TRAIL, 8'hab);
      bus_idle(2);
      chk("eff", 9'h02b, {2'b00, eff[CDT_IX_CLK_TRAIL]});
      // Second reset mid-run clears every override
      rst_n <= 1'b0;
      repeat (2) @(negedge clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
      chk("ovr", 9'h000, ovr);
      chk("eff", {2'b00, exp_auto(4)}, {2'b00, eff[4]});
      conclude();
   end
endmodule // cdt_timing_override_tb_top
